// ---- pkg/ipr_pkg.sv ----
// Constants for the extra interrupt enable and priority registers.
// Assumes a core that reaches them as 8-bit special function registers.
// How it works
// - Extra enable bits: ADC7 SPI6 PCA5 UART1-4 I2C1 USB0.
// - Enable one passes source, zero blocks it.
// - Base priority: T2,UART0,T1,INT1,T0,INT0 in bits 5:0.
// - Base priority at B8h, resets to 00h.
// - Extra priority bits mirror extra enable layout.
// - Extra priority at B7h, resets to 00h.
// - Priority one means high level, zero low.
// - Extra enable at A7h, resets to 00h.
package ipr_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] IPR_EXTRA_EN_ADDR   = 8'ha7;
  localparam logic [7:0] IPR_EXTRA_PRIO_ADDR = 8'hb7;
  localparam logic [7:0] IPR_BASE_PRIO_ADDR  = 8'hb8;
  localparam logic [7:0] IPR_EXTRA_EN_RST    = 8'h00;
  localparam logic [7:0] IPR_EXTRA_PRIO_RST  = 8'h00;
  localparam logic [7:0] IPR_BASE_PRIO_RST   = 8'h00;

  // ==========================================================================
  // Field layout
  localparam logic [7:0] IPR_EXTRA_MASK = 8'hf3;
  localparam logic [7:0] IPR_BASE_MASK  = 8'h3f;
  localparam int IPR_NUM_BASE  = 6;
  localparam int IPR_NUM_EXTRA = 6;
  localparam int IPR_NUM_SRC   = 12;

  // ==========================================================================
  // Service level tracker states, Gray coded along idle-low-nested-high.
  typedef enum logic [1:0] {
    IPR_IDLE   = 2'h0,
    IPR_LOW    = 2'h1,
    IPR_NESTED = 2'h3,
    IPR_HIGH   = 2'h2
  } ipr_state_t;

  // Packs an extra register into six live bits, dropping reserved 3:2.
  function automatic logic [5:0] ipr_pack(input logic [7:0] r);
    ipr_pack = {r[7:4], r[1:0]};
  endfunction : ipr_pack

endpackage : ipr_pkg

// ---- rtl/ipr_level_track.sv ----
// Service level tracker: decides which pending level may be taken now.
// Assumes the core pulses ack on vector entry and reti on return.
`timescale 1ns/1ps
module ipr_level_track (
  input  wire logic clk_i,       // Core clock.
  input  wire logic rstn_i,      // Asynchronous reset, active low.
  input  wire logic ce_i,        // Clock enable.
  input  wire logic hi_pend_i,   // Enabled high level request pending.
  input  wire logic lo_pend_i,   // Enabled low level request pending.
  input  wire logic ack_i,       // Core enters a service routine.
  input  wire logic ack_hi_i,    // Entered routine is high level.
  input  wire logic reti_i,      // Core returns from a routine.
  output logic      take_hi_o,   // High request may interrupt now.
  output logic      take_lo_o,   // Low request may interrupt now.
  output logic      in_high_o    // A high level routine is running.
);
  import ipr_pkg::*;

  ipr_state_t state;
  ipr_state_t next_state;

  // ==========================================================================
  // Nesting state
  always_comb begin
    next_state = state;
    case (state)
      IPR_IDLE: begin
        if (ack_i) next_state = ack_hi_i ? IPR_HIGH : IPR_LOW;
      end
      IPR_LOW: begin
        if (ack_i && ack_hi_i) next_state = IPR_NESTED;
        else if (reti_i) next_state = IPR_IDLE;
      end
      IPR_NESTED: begin
        if (reti_i) next_state = IPR_LOW;
      end
      IPR_HIGH: begin
        if (reti_i) next_state = IPR_IDLE;
      end
      default: next_state = IPR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= IPR_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Take decisions, registered so the outputs come from flip-flops.
  // A high routine blocks everything; a low routine blocks only low.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_hi_o <= 1'b0;
      take_lo_o <= 1'b0;
      in_high_o <= 1'b0;
    end else if (ce_i) begin
      take_hi_o <= hi_pend_i && (next_state == IPR_IDLE ||
                                 next_state == IPR_LOW);
      take_lo_o <= lo_pend_i && !hi_pend_i &&
                   next_state == IPR_IDLE;
      in_high_o <= next_state == IPR_HIGH || next_state == IPR_NESTED;
    end
  end

  // ==========================================================================
  // Checks
  // The second step must still be in low service: a return in the first
  // step legally leads to plain high service instead of nesting.
  sequence s_nest;
    ce_i && state == IPR_LOW ##1 ce_i && state == IPR_LOW && ack_i &&
    ack_hi_i;
  endsequence

  property p_nest;
    @(posedge clk_i) disable iff (!rstn_i)
      s_nest |=> state == IPR_NESTED;
  endproperty
  a_nest: assert property (p_nest) else $error("High did not nest.");

  property p_no_same_level;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && (state == IPR_HIGH || state == IPR_NESTED) && !reti_i
      |=> !take_hi_o && !take_lo_o;
  endproperty
  a_no_same_level: assert property (p_no_same_level)
    else $error("Request taken during high service.");

  property p_low_blocks_low;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && state == IPR_LOW && !reti_i |=> !take_lo_o;
  endproperty
  a_low_blocks_low: assert property (p_low_blocks_low)
    else $error("Low preempted low.");

endmodule : ipr_level_track

// ---- rtl/ipr_regs.sv ----
// Extra interrupt enable and both priority registers, with level gating.
// Assumes the core's special function register port and a single clock;
// the main enable register and vector logic sit outside.
`timescale 1ns/1ps
module ipr_regs #(
  parameter int NSRC = ipr_pkg::IPR_NUM_SRC
) (
  input  wire logic            clk_i,        // Core clock, 125 MHz.
  input  wire logic            rstn_i,       // Asynchronous reset, low.
  input  wire logic            ce_i,         // Clock enable.
  input  wire logic [7:0]      sfr_addr_i,   // Register address.
  input  wire logic            sfr_wr_i,     // Write strobe.
  input  wire logic [7:0]      sfr_wdata_i,  // Write data.
  input  wire logic            sfr_rd_i,     // Read strobe.
  output logic      [7:0]      sfr_rdata_o,  // Read data, one cycle later.
  output logic                 sfr_hit_o,    // Read one cycle earlier hit this block.
  input  wire logic            global_en_i,  // Main enable from core.
  input  wire logic [5:0]      base_en_i,    // Base source enables.
  input  wire logic [NSRC-1:0] src_flag_i,   // Source request flags.
  input  wire logic            ack_i,        // Core takes a vector.
  input  wire logic            ack_hi_i,     // Taken vector is high.
  input  wire logic            reti_i,       // Core returns.
  output logic      [NSRC-1:0] src_en_o,     // Per source enable.
  output logic      [NSRC-1:0] src_prio_o,   // Per source priority.
  output logic                 take_hi_o,    // High request may enter.
  output logic                 take_lo_o,    // Low request may enter.
  output logic                 in_high_o     // High routine running.
);
  import ipr_pkg::*;

  logic [7:0]      extra_irq_enable;
  logic [7:0]      extra_irq_priority;
  logic [7:0]      base_irq_priority;
  logic            hi_pend;
  logic            lo_pend;
  logic [NSRC-1:0] next_en;
  logic [NSRC-1:0] next_prio;
  logic [NSRC-1:0] live;

  // ==========================================================================
  // Register writes. Reserved bits are not stored, so a stray write of
  // one there cannot leak into the source vectors and reads back as zero.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      extra_irq_enable <= IPR_EXTRA_EN_RST;
    end else if (ce_i && sfr_wr_i && sfr_addr_i == IPR_EXTRA_EN_ADDR) begin
      extra_irq_enable <= sfr_wdata_i & IPR_EXTRA_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      extra_irq_priority <= IPR_EXTRA_PRIO_RST;
    end else if (ce_i && sfr_wr_i && sfr_addr_i == IPR_EXTRA_PRIO_ADDR) begin
      extra_irq_priority <= sfr_wdata_i & IPR_EXTRA_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      base_irq_priority <= IPR_BASE_PRIO_RST;
    end else if (ce_i && sfr_wr_i && sfr_addr_i == IPR_BASE_PRIO_ADDR) begin
      base_irq_priority <= sfr_wdata_i & IPR_BASE_MASK;
    end
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o   <= 1'b0;
    end else if (ce_i) begin
      sfr_hit_o   <= 1'b0;
      sfr_rdata_o <= 8'h00;
      if (sfr_rd_i) begin
        case (sfr_addr_i)
          IPR_EXTRA_EN_ADDR: begin
            sfr_rdata_o <= extra_irq_enable;
            sfr_hit_o   <= 1'b1;
          end
          IPR_EXTRA_PRIO_ADDR: begin
            sfr_rdata_o <= extra_irq_priority;
            sfr_hit_o   <= 1'b1;
          end
          IPR_BASE_PRIO_ADDR: begin
            sfr_rdata_o <= base_irq_priority;
            sfr_hit_o   <= 1'b1;
          end
          default: begin
            sfr_rdata_o <= 8'h00;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Source vectors: bits 5:0 base sources, 11:6 USB, I2C, UART1, PCA,
  // SPI, ADC. The main enable gates the requests of all of them, but not src_en_o.
  always_comb begin
    next_en   = {ipr_pack(extra_irq_enable), base_en_i};
    next_prio = {ipr_pack(extra_irq_priority),
                 base_irq_priority[5:0]};
  end

  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_live
      assign live[i] = src_flag_i[i] && next_en[i] && global_en_i;
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_en_o   <= '0;
      src_prio_o <= '0;
      hi_pend    <= 1'b0;
      lo_pend    <= 1'b0;
    end else if (ce_i) begin
      src_en_o   <= next_en;
      src_prio_o <= next_prio;
      hi_pend    <= |(live & next_prio);
      lo_pend    <= |(live & ~next_prio);
    end
  end

  ipr_level_track u_track (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .hi_pend_i (hi_pend),
    .lo_pend_i (lo_pend),
    .ack_i     (ack_i),
    .ack_hi_i  (ack_hi_i),
    .reti_i    (reti_i),
    .take_hi_o (take_hi_o),
    .take_lo_o (take_lo_o),
    .in_high_o (in_high_o)
  );

  // ==========================================================================
  // Checks
  property p_en_write;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && sfr_wr_i && sfr_addr_i == IPR_EXTRA_EN_ADDR
      |=> extra_irq_enable == ($past(sfr_wdata_i) & 8'hf3);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("Extra enable write lost.");

  property p_reserved;
    @(posedge clk_i) disable iff (!rstn_i)
      extra_irq_enable[3:2] == 2'h0 && extra_irq_priority[3:2] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bit set.");

  property p_base_write;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && sfr_wr_i && sfr_addr_i == 8'hb8
      |=> base_irq_priority == ($past(sfr_wdata_i) & 8'h3f);
  endproperty
  a_base_write: assert property (p_base_write)
    else $error("Base priority write lost.");

  sequence s_rd_base;
    ce_i && sfr_rd_i && sfr_addr_i == 8'hb8 && !sfr_wr_i;
  endsequence

  property p_base_read;
    @(posedge clk_i) disable iff (!rstn_i)
      s_rd_base |=> sfr_hit_o && sfr_rdata_o == $past(base_irq_priority);
  endproperty
  a_base_read: assert property (p_base_read)
    else $error("Base priority read wrong.");

  property p_extra_write;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && sfr_wr_i && sfr_addr_i == 8'hb7
      |=> extra_irq_priority == ($past(sfr_wdata_i) & 8'hf3);
  endproperty
  a_extra_write: assert property (p_extra_write)
    else $error("Extra priority write lost.");

  property p_en_read;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'ha7
      |=> sfr_rdata_o == $past(extra_irq_enable);
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("Extra enable read wrong.");

  property p_blocked;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && (live == '0) |=> !hi_pend && !lo_pend;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("Disabled source requested.");

  property p_level;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && global_en_i && |(src_flag_i & next_en & next_prio)
      |=> hi_pend;
  endproperty
  a_level: assert property (p_level)
    else $error("High priority source not high.");

  property p_preempt;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && hi_pend && in_high_o == 1'b0 && !ack_i && !reti_i
      |=> take_hi_o;
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("High did not preempt.");

endmodule : ipr_regs

// ---- bench/ipr_regs_tb.sv ----
// Self-checking bench for the extra interrupt enable and priority registers.
// Assumes ipr_pkg is compiled first; the bench plays the core's part.
`timescale 1ns/1ps
module ipr_regs_tb;
  import ipr_pkg::*;

  logic        clk_i;
  logic        rstn_i;
  logic        ce_i;
  logic [7:0]  sfr_addr_i;
  logic        sfr_wr_i;
  logic [7:0]  sfr_wdata_i;
  logic        sfr_rd_i;
  logic [7:0]  sfr_rdata_o;
  logic        sfr_hit_o;
  logic        global_en_i;
  logic [5:0]  base_en_i;
  logic [11:0] src_flag_i;
  logic        ack_i;
  logic        ack_hi_i;
  logic        reti_i;
  logic [11:0] src_en_o;
  logic [11:0] src_prio_o;
  logic        take_hi_o;
  logic        take_lo_o;
  logic        in_high_o;
  int          err_count;
  int          check_count;
  int          xpos[6] = '{0, 1, 4, 5, 6, 7};

  ipr_regs #(.NSRC(12)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
    .global_en_i(global_en_i), .base_en_i(base_en_i),
    .src_flag_i(src_flag_i), .ack_i(ack_i), .ack_hi_i(ack_hi_i),
    .reti_i(reti_i), .src_en_o(src_en_o), .src_prio_o(src_prio_o),
    .take_hi_o(take_hi_o), .take_lo_o(take_lo_o), .in_high_o(in_high_o)
  );

  // ==========================================================================
  // Clock, reset and helpers
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Strobe is dropped and one edge passes, so back-to-back calls never
  // drive the strobe twice in one time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    tick(1);
    sfr_wr_i    = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input logic hit);
    sfr_addr_i = a;
    sfr_rd_i   = 1'b1;
    tick(1);
    sfr_rd_i   = 1'b0;
    chk({4'h0, sfr_rdata_o}, {4'h0, exp}, "read data");
    chk({11'h0, sfr_hit_o}, {11'h0, hit}, "read hit");
    tick(1);
  endtask : rd

  task automatic pulse(input logic hi, input logic ret);
    ack_hi_i = hi;
    ack_i    = ~ret;
    reti_i   = ret;
    tick(1);
    ack_i    = 1'b0;
    reti_i   = 1'b0;
  endtask : pulse

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Scenarios
  task automatic test_reset_and_mask;
    rd(IPR_EXTRA_EN_ADDR, 8'h00, 1'b1);
    rd(IPR_EXTRA_PRIO_ADDR, 8'h00, 1'b1);
    rd(IPR_BASE_PRIO_ADDR, 8'h00, 1'b1);
    wr(IPR_EXTRA_EN_ADDR, 8'hf3);
    wr(IPR_EXTRA_PRIO_ADDR, 8'hff);
    wr(IPR_BASE_PRIO_ADDR, 8'hff);
    wr(8'ha8, 8'hff);
    rd(IPR_EXTRA_EN_ADDR, 8'hf3, 1'b1);
    rd(IPR_EXTRA_PRIO_ADDR, 8'hf3, 1'b1);
    rd(IPR_BASE_PRIO_ADDR, 8'h3f, 1'b1);
    rd(8'ha8, 8'h00, 1'b0);
    $display("test reset_and_mask done");
  endtask : test_reset_and_mask

  task automatic test_bit_map;
    base_en_i = 6'h00;
    for (int k = 0; k < 6; k++) begin
      wr(IPR_EXTRA_EN_ADDR, 8'h01 << xpos[k]);
      wr(IPR_EXTRA_PRIO_ADDR, 8'h01 << xpos[k]);
      wr(IPR_BASE_PRIO_ADDR, 8'h01 << k);
      tick(1);
      chk(src_en_o, 12'h040 << k, "extra enable bit");
      chk(src_prio_o, (12'h040 << k) | (12'h001 << k),
          "priority bit");
    end
    base_en_i = 6'h2a;
    wr(IPR_EXTRA_EN_ADDR, 8'h00);
    wr(IPR_EXTRA_PRIO_ADDR, 8'h00);
    wr(IPR_BASE_PRIO_ADDR, 8'h00);
    tick(1);
    chk(src_en_o, 12'h02a, "base enables");
    chk(src_prio_o, 12'h000, "priorities cleared");
    $display("test bit_map done");
  endtask : test_bit_map

  // With the clock enable low nothing may move: no write, no read, no
  // refresh of the registered source vectors.
  task automatic test_freeze;
    ce_i      = 1'b0;
    base_en_i = 6'h15;
    wr(IPR_BASE_PRIO_ADDR, 8'h15);
    rd(IPR_BASE_PRIO_ADDR, 8'h00, 1'b0);
    chk(src_en_o, 12'h02a, "frozen enables");
    ce_i = 1'b1;
    rd(IPR_BASE_PRIO_ADDR, 8'h00, 1'b1);
    chk(src_en_o, 12'h015, "enables resume");
    $display("test freeze done");
  endtask : test_freeze

  task automatic test_preempt;
    base_en_i  = 6'h01;
    wr(IPR_EXTRA_PRIO_ADDR, 8'h80);
    src_flag_i = 12'h800;
    tick(3);
    chk({10'h0, take_hi_o, take_lo_o}, 12'h000, "blocked source");
    wr(IPR_EXTRA_EN_ADDR, 8'h80);
    tick(2);
    chk({10'h0, take_hi_o, take_lo_o}, 12'h002, "high take");
    src_flag_i = 12'h001;
    tick(3);
    chk({10'h0, take_hi_o, take_lo_o}, 12'h001, "low take");
    global_en_i = 1'b0;
    tick(3);
    chk({10'h0, take_hi_o, take_lo_o}, 12'h000, "main disable");
    global_en_i = 1'b1;
    tick(3);
    pulse(1'b0, 1'b0);
    tick(2);
    chk({10'h0, take_hi_o, take_lo_o}, 12'h000, "same level");
    src_flag_i = 12'h801;
    tick(3);
    chk({10'h0, take_hi_o, take_lo_o}, 12'h002, "preempt");
    pulse(1'b1, 1'b0);
    src_flag_i = 12'h001;
    tick(2);
    chk({10'h0, take_hi_o, in_high_o}, 12'h001, "nested high");
    pulse(1'b0, 1'b1);
    tick(2);
    chk({10'h0, in_high_o, take_lo_o}, 12'h000, "back to low");
    pulse(1'b0, 1'b1);
    tick(3);
    chk({10'h0, take_hi_o, take_lo_o}, 12'h001, "idle again");
    src_flag_i = 12'h000;
    $display("test preempt done");
  endtask : test_preempt

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    err_count   = 0;
    check_count = 0;
    rstn_i      = 1'b0;
    ce_i        = 1'b1;
    sfr_addr_i  = 8'h00;
    sfr_wr_i    = 1'b0;
    sfr_wdata_i = 8'h00;
    sfr_rd_i    = 1'b0;
    global_en_i = 1'b1;
    base_en_i   = 6'h00;
    src_flag_i  = 12'h000;
    ack_i       = 1'b0;
    ack_hi_i    = 1'b0;
    reti_i      = 1'b0;
    tick(4);
    rstn_i = 1'b1;
    tick(1);
    test_reset_and_mask();
    test_bit_map();
    test_freeze();
    test_preempt();
    stop_test();
  end

  // The tests need well under a thousand cycles; this leaves wide margin.
  initial begin
    #20000;
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end

endmodule : ipr_regs_tb
